// [inc/pwr_pkg.sv]
package pwr_pkg;
  localparam int WORD_W = 14;
  localparam int CLK_MHZ = 125;
  // power-up timer: 72 ms of pclk
  localparam int POWERUP_TIMER_MS = 72;
  localparam int POWERUP_TIMER_CYC = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
  // oscillator start-up: 1024 periods, one period per pclk
  localparam int OST_TOSC = 1024;
  localparam int OST_CYC = OST_TOSC;
  // watchdog: 18 ms of its own oscillator
  localparam int WDT_MS = 18;
  localparam int WDT_OSC_KHZ = 1000;
  localparam int WDT_EDGES = WDT_MS * WDT_OSC_KHZ;
  localparam int WCNT_W = 24;
  localparam int PS_W = 7;
  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_STATUS = 16'h0003;
  localparam logic [15:0] IDX_POWER_CONTROL_STATUS_REG = 16'h000e;
  localparam logic [15:0] IDX_OPTION = 16'h0081;
  localparam logic [15:0] IDX_CONFIG = 16'h2007;
  // configuration fuse word fields
  localparam int CFG_PAR_EN = 7;
  localparam int CFG_BOR = 6;
  localparam int CFG_CP = 4;
  localparam int CFG_POWERUP_TIMER_ENABLE_FUSE = 3;
  localparam int CFG_WATCHDOG_ENABLE_FUSE = 2;
  localparam int CFG_FOSC = 0;
  // prescaler_and_pin_setup fields
  localparam int OPT_PSA = 3;
  localparam int OPT_PS = 0;
  // power_control_status_reg fields
  localparam int POWER_CONTROL_STATUS_REG_PAR_EN = 7;
  localparam int POWER_CONTROL_STATUS_REG_PER = 2;
  localparam int POWER_CONTROL_STATUS_REG_POR = 1;
  localparam int POWER_CONTROL_STATUS_REG_BOR = 0;
  // status register fields
  localparam int STAT_TO = 4;
  localparam int STAT_PD = 3;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] CFG_RST = 8'hff;

  typedef enum logic [1:0] {
    low_power_osc_mode = 2'b00,
    crystal_osc_mode = 2'b01,
    high_speed_osc_mode = 2'b10,
    resistor_capacitor_osc_mode = 2'b11
  } pwr_osc_t;

  typedef enum logic [2:0] {
    st_por = 3'b000,
    st_powerup_timer = 3'b001,
    st_ost = 3'b010,
    st_run = 3'b011,
    st_sleep = 3'b100,
    st_rst = 3'b101
  } pwr_state_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
    logic [1:0] par;
  } pwr_fetch_t;

  typedef struct packed {
    logic clr_wdt;
    logic sleep;
  } pwr_cmd_t;
endpackage

// [src/pwr_sync.sv]
`timescale 1ns/1ns
module pwr_sync import pwr_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] q1;
    logic [W-1:0] q2;
  } pwr_sync_st_t;

  pwr_sync_st_t s_r;
  pwr_sync_st_t s_nxt;

  if (W < 1) begin : g_chk
    $error("pwr_sync: width must be positive");
  end

  always_comb begin
    s_nxt.q1 = d;
    s_nxt.q2 = s_r.q1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // ones: power-on pin busy, fuses unprogrammed until sampled
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q2;
endmodule

// [src/pwr_parity.sv]
`timescale 1ns/1ns
module pwr_parity import pwr_pkg::*; #(
  parameter int W = WORD_W
) (
  // program word and its stored pair
  input wire logic [W-1:0] word,
  input wire logic [1:0] par,
  // pair to store, and check result
  output logic [1:0] gen_par,
  output logic err
);
  logic even_x;
  logic odd_x;

  if (W < 2) begin : g_chk
    $error("pwr_parity: word needs at least two bits");
  end

  always_comb begin
    even_x = 1'b0;
    odd_x = 1'b0;
    for (int i = 0; i < W; i++) begin
      if (i % 2 == 0) begin
        even_x = even_x ^ word[i];
      end else begin
        odd_x = odd_x ^ word[i];
      end
    end
  end

  // bit 0 even parity over even bits, bit 1 odd parity over odd bits
  assign gen_par = {~odd_x, even_x};
  // even bit xor even bits, inverted odd bit xor odd bits
  assign err = (even_x ^ par[0]) | (odd_x ^ ~par[1]);
endmodule

// [src/pwr_top.sv]
// Behaviour
// - two parity bits per program word, even over even bits, odd over odd.
// - fetch check xors even bits with even bit, odd bits with inverted odd bit.
// - a parity error resets the device and clears the parity error flag.
// - only software or power-on reset sets the parity error flag; parity logic never does.
// - the failing address is neither stored nor reported.
// - fuse bit 7 zero disables parity checking, one enables it.
// - start-up waits follow oscillator mode, power-up timer fuse and cause.
// - the watchdog counts its own free-running oscillator, also in sleep.
// - a watchdog time-out outside sleep resets the device.
// - a watchdog time-out in sleep wakes the device instead.
// - watchdog enable fuse cleared disables the watchdog for good.
// - with no prescaler the watchdog times out after nominal 18 ms.
// - software may assign the prescaler to the watchdog, up to 1:128.
// - clear-watchdog or sleep clears counter and assigned prescaler.
// - a watchdog time-out clears the time-out status flag.
// - clear-watchdog zeroes the prescaler count, keeps its assignment.
// - power-up timer starts after power-on delay, start-up timer after it.
// - power-on reset sets the parity error flag to one.
`timescale 1ns/1ns
module pwr_top import pwr_pkg::*; #(
  parameter int POWERUP_TIMER_CYCLES = POWERUP_TIMER_CYC,
  parameter int OST_CYCLES = OST_CYC,
  parameter int WDT_TICKS = WDT_EDGES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic por_pin,
  input wire logic bor_pin,
  input wire logic wdt_osc_pin,
  input wire logic [7:0] cfg_fuse_pin,
  // core fetch path and commands
  input wire pwr_fetch_t fetch,
  input wire pwr_cmd_t cmd,
  input wire logic [WORD_W-1:0] prog_word,
  output logic [1:0] prog_par,
  // reset network
  output logic core_reset,
  output logic wake,
  output logic sleeping
);
  typedef struct packed {
    pwr_state_t state;
    logic waking;
    logic [31:0] tmr;
    logic [PS_W-1:0] presc;
    logic [WCNT_W-1:0] wcnt;
    logic wosc_q;
    logic [7:0] cfg;
    logic [7:0] option;
    logic parity_error_reset_flag;
    logic por_f;
    logic bor_f;
    logic to_f;
    logic pd_f;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic core_reset;
    logic wake;
    logic sleeping;
    logic [1:0] prog_par;
  } pwr_top_st_t;

  // parity error flag starts at one on power-on
  localparam pwr_top_st_t S_RST = '{
    state: st_por,
    cfg: CFG_RST,
    option: OPTION_RST,
    parity_error_reset_flag: 1'b1,
    to_f: 1'b1,
    pd_f: 1'b1,
    core_reset: 1'b1,
    default: '0
  };
  localparam logic [WCNT_W-1:0] WDT_TOP = WCNT_W'(WDT_TICKS - 1);
  localparam logic [31:0] POWERUP_TIMER_TOP = 32'(POWERUP_TIMER_CYCLES - 1);
  localparam logic [31:0] OST_TOP = 32'(OST_CYCLES - 1);

  if (POWERUP_TIMER_CYCLES < 1 || OST_CYCLES < 9 || WDT_TICKS < 1 || WDT_TICKS >= 2**WCNT_W)
  begin : g_chk
    $error("pwr_top: timer counts out of range");
  end

  function automatic logic [15:0] idx_of(input logic [31:0] a);
    return a[17:2];
  endfunction

  function automatic logic hit(input logic [31:0] a);
    logic [15:0] i;
    i = idx_of(a);
    return (a[1:0] == 2'b00) && (a[31:18] == '0) &&
      (i == IDX_STATUS || i == IDX_POWER_CONTROL_STATUS_REG || i == IDX_OPTION || i == IDX_CONFIG);
  endfunction

  function automatic logic is_rc(input logic [7:0] c);
    return pwr_osc_t'(c[CFG_FOSC +: 2]) == resistor_capacitor_osc_mode;
  endfunction

  function automatic logic powerup_timer_on(input logic [7:0] c);
    return ~c[CFG_POWERUP_TIMER_ENABLE_FUSE];
  endfunction

  pwr_top_st_t s;
  pwr_top_st_t n;
  logic [10:0] pins_s;
  logic por_s;
  logic bor_s;
  logic wosc_s;
  logic [7:0] cfg_s;
  logic perr;
  logic [1:0] gen_prog;
  logic acc;
  logic wr_opt;
  logic wr_power_control_status_reg;
  logic prescaler_assign_select;
  logic [PS_W-1:0] ps_top;
  logic wdt_edge;
  logic wdt_on;
  logic wdt_tick;
  logic wdt_to;
  logic clr;
  logic par_hit;
  logic bor_hit;

  // watchdog oscillator arrives as its own pin, free of pclk gating
  pwr_sync #(.W(11)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({cfg_fuse_pin, wdt_osc_pin, bor_pin, por_pin}),
    .q(pins_s)
  );
  assign {cfg_s, wosc_s, bor_s, por_s} = pins_s;

  pwr_parity #(.W(WORD_W)) u_chk (
    .word(fetch.word),
    .par(fetch.par),
    .gen_par(),
    .err(perr)
  );

  pwr_parity #(.W(WORD_W)) u_gen (
    .word(prog_word),
    .par(2'b00),
    .gen_par(gen_prog),
    .err()
  );

  assign acc = psel & penable & s.pready & pwrite & hit(paddr);
  assign wr_opt = acc & (idx_of(paddr) == IDX_OPTION);
  assign wr_power_control_status_reg = acc & (idx_of(paddr) == IDX_POWER_CONTROL_STATUS_REG);

  assign prescaler_assign_select = s.option[OPT_PSA];
  assign ps_top = PS_W'((8'd1 << s.option[OPT_PS +: 3]) - 8'd1);
  assign wdt_edge = wosc_s & ~s.wosc_q;
  assign wdt_on = s.cfg[CFG_WATCHDOG_ENABLE_FUSE] & (s.state == st_run || s.state == st_sleep);
  assign wdt_tick = wdt_edge & (~prescaler_assign_select | (s.presc == ps_top));
  assign wdt_to = wdt_on & wdt_tick & (s.wcnt == WDT_TOP);
  assign clr = (cmd.clr_wdt | cmd.sleep) & (s.state == st_run);
  // only the flag is kept, no failing address
  assign par_hit = fetch.valid & s.cfg[CFG_PAR_EN] & perr & (s.state == st_run);
  assign bor_hit = bor_s & s.cfg[CFG_BOR] & (s.state != st_por);

  always_comb begin
    n = s;
    n.wake = 1'b0;
    n.prog_par = gen_prog;
    n.pready = psel & ~penable;
    n.pslverr = 1'b0;
    if (psel & ~penable) begin
      n.pslverr = ~hit(paddr);
      n.prdata = '0;
      unique case (hit(paddr) ? idx_of(paddr) : 16'hffff)
        IDX_STATUS: begin
          n.prdata[STAT_TO] = s.to_f;
          n.prdata[STAT_PD] = s.pd_f;
        end
        IDX_POWER_CONTROL_STATUS_REG: begin
          n.prdata[POWER_CONTROL_STATUS_REG_PAR_EN] = s.cfg[CFG_PAR_EN];
          n.prdata[POWER_CONTROL_STATUS_REG_PER] = s.parity_error_reset_flag;
          n.prdata[POWER_CONTROL_STATUS_REG_POR] = s.por_f;
          n.prdata[POWER_CONTROL_STATUS_REG_BOR] = s.bor_f;
        end
        IDX_OPTION: n.prdata[7:0] = s.option;
        IDX_CONFIG: n.prdata[7:0] = s.cfg;
        default: n.prdata = '0;
      endcase
    end
    if (wr_opt) begin
      n.option = pwdata[7:0];
    end
    // software and power-on reset are the only setters of the parity error flag
    if (wr_power_control_status_reg) begin
      n.parity_error_reset_flag = pwdata[POWER_CONTROL_STATUS_REG_PER];
      n.por_f = pwdata[POWER_CONTROL_STATUS_REG_POR];
      n.bor_f = pwdata[POWER_CONTROL_STATUS_REG_BOR];
    end
    // watchdog divider and counter
    n.wosc_q = wosc_s;
    if (wdt_edge & prescaler_assign_select) begin
      n.presc = (s.presc == ps_top) ? '0 : s.presc + 1'b1;
    end
    if (wdt_tick) begin
      n.wcnt = wdt_to ? '0 : s.wcnt + 1'b1;
    end
    // prescaler count cleared, assignment bit untouched
    if (clr | ~wdt_on) begin
      n.wcnt = '0;
      if (prescaler_assign_select) begin
        n.presc = '0;
      end
    end
    if (clr) begin
      n.to_f = 1'b1;
      n.pd_f = ~cmd.sleep;
    end
    // cleared on time-out and left clear through the reset
    if (wdt_to) begin
      n.to_f = 1'b0;
    end
    // start-up and reset sequencing
    n.tmr = s.tmr + 32'd1;
    unique case (s.state)
      st_por: begin
        n.cfg = cfg_s;
        n.tmr = '0;
        if (!por_s) begin
          // power-up timer only after the power-on delay
          if (powerup_timer_on(cfg_s)) begin
            n.state = st_powerup_timer;
          end else if (is_rc(cfg_s)) begin
            n.state = st_run;
          end else begin
            n.state = st_ost;
          end
        end
      end
      st_powerup_timer: begin
        if (s.tmr == POWERUP_TIMER_TOP) begin
          n.tmr = '0;
          n.state = is_rc(s.cfg) ? st_run : st_ost;
        end
      end
      st_ost: begin
        if (s.tmr == OST_TOP) begin
          n.state = st_run;
          n.wake = s.waking;
          n.waking = 1'b0;
        end
      end
      st_run: begin
        // parity reset wins over the fetched instruction
        if (par_hit) begin
          n.state = st_rst;
          n.parity_error_reset_flag = 1'b0;
        end else if (wdt_to) begin
          n.state = st_rst;
        end else if (cmd.sleep) begin
          n.state = st_sleep;
        end
      end
      st_sleep: begin
        if (wdt_to) begin
          n.tmr = '0;
          // wake instead of reset
          if (is_rc(s.cfg)) begin
            n.state = st_run;
            n.wake = 1'b1;
          end else begin
            n.state = st_ost;
            n.waking = 1'b1;
          end
        end
      end
      st_rst: n.state = st_run;
      default: n.state = st_por;
    endcase
    // brown-out always runs the power-up timer
    if (bor_hit) begin
      n.state = st_powerup_timer;
      n.tmr = '0;
      n.bor_f = 1'b0;
      n.waking = 1'b0;
      n.wake = 1'b0;
    end
    n.core_reset = !(n.state == st_run || n.state == st_sleep);
    n.sleeping = (n.state == st_sleep);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= S_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign prog_par = s.prog_par;
  assign core_reset = s.core_reset;
  assign wake = s.wake;
  assign sleeping = s.sleeping;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rst_pulse;
    s.state == st_rst ##1 s.state == st_run;
  endsequence

  property p_par_reset;
    par_hit && !bor_hit |=> !s.parity_error_reset_flag && s.core_reset ##0 s_rst_pulse;
  endproperty
  a_par_reset: assert property (p_par_reset) else $error("parity error did not reset");

  property p_per_set;
    $rose(s.parity_error_reset_flag) |-> $past(wr_power_control_status_reg) && $past(pwdata[POWER_CONTROL_STATUS_REG_PER]);
  endproperty
  a_per_set: assert property (p_per_set) else $error("parity flag set by hardware");

  property p_par_off;
    fetch.valid && perr && !s.cfg[CFG_PAR_EN] && s.state == st_run && !wdt_to && !bor_hit
      && !cmd.sleep |=> s.state == st_run && s.parity_error_reset_flag == $past(s.parity_error_reset_flag);
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity checked while off");

  property p_wdt_rst;
    s.state == st_run && wdt_to && !par_hit && !bor_hit |=> s_rst_pulse;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog did not reset");

  property p_wdt_wake;
    s.state == st_sleep && wdt_to && is_rc(s.cfg) && !bor_hit |=> s.wake && !s.core_reset;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog did not wake");

  property p_wdt_off;
    !s.cfg[CFG_WATCHDOG_ENABLE_FUSE] |-> !wdt_to && s.wcnt == '0;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog counted");

  property p_clr;
    clr && prescaler_assign_select && !wr_opt |=> s.wcnt == '0 && s.presc == '0 && $stable(s.option[OPT_PSA]);
  endproperty
  a_clr: assert property (p_clr) else $error("watchdog clear failed");

  property p_to_clr;
    wdt_to |=> !s.to_f ##1 (!s.to_f || $past(clr));
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("time-out flag not cleared");

  property p_ost_len;
    s.state == st_powerup_timer && !bor_hit ##1 s.state == st_ost |-> (s.state == st_ost || bor_hit)[*8];
  endproperty
  a_ost_len: assert property (p_ost_len) else $error("start-up timer cut short");
endmodule

// [verification/pwr_core_model.sv]
`timescale 1ns/1ns
module pwr_core_model import pwr_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // block state
  input wire logic core_reset,
  input wire logic sleeping,
  // bench requests
  input wire logic corrupt,
  input wire pwr_cmd_t cmd_req,
  // fetch path and commands
  output pwr_fetch_t fetch,
  output pwr_cmd_t cmd
);
  logic [WORD_W-1:0] pc_r;
  logic run;

  assign run = !core_reset && !sleeping;

  // even sum to bit 0, inverted odd sum to bit 1
  function automatic logic [1:0] pair(input logic [WORD_W-1:0] w);
    logic [1:0] p;
    p = 2'b10;
    for (int i = 0; i < WORD_W; i += 2) begin
      p = p ^ {w[i+1], w[i]};
    end
    return p;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= '0;
      fetch <= '0;
      cmd <= '0;
    end else begin
      cmd <= cmd_req;
      fetch.valid <= run;
      if (run) begin
        pc_r <= pc_r + 1'b1;
        fetch.word <= pc_r;
        fetch.par <= pair(pc_r) ^ {1'b0, corrupt};
      end else begin
        // no stale word while idle
        fetch.word <= ~fetch.word;
        fetch.par <= ~fetch.par;
      end
    end
  end
endmodule

// [verification/test_pwr_top.sv]
`timescale 1ns/1ns
module test_pwr_top import pwr_pkg::*; ();
  localparam int PW = 50;
  localparam int OS = 16;
  localparam logic [31:0] A_STAT = {14'h0000, IDX_STATUS, 2'b00};
  localparam logic [31:0] A_POWER_CONTROL_STATUS_REG = {14'h0000, IDX_POWER_CONTROL_STATUS_REG, 2'b00};
  localparam logic [31:0] A_OPT = {14'h0000, IDX_OPTION, 2'b00};
  localparam logic [31:0] A_CFG = {14'h0000, IDX_CONFIG, 2'b00};
  localparam pwr_cmd_t CLR = 2'b10;
  localparam pwr_cmd_t SLP = 2'b01;
  // fuse word beside its start-up wait
  localparam logic [7:0] PU_F [4] = '{8'h7b, 8'hf7, 8'hfd, 8'hf5};
  localparam int PU_LO [4] = '{0, PW, OS, PW + OS};
  // program word beside its stored pair
  localparam logic [15:0] PAR_ROWS [6] = '{16'h0002, 16'h0007, 16'h0008,
    16'hfffd, 16'haaa8, 16'h000d};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, core_reset, wake, sleeping;
  logic por_pin = 1'b1;
  logic bor = 1'b0;
  logic osc = 1'b0;
  logic corrupt = 1'b0;
  logic [7:0] fuse = 8'hff;
  pwr_cmd_t cmd_req = '0;
  pwr_cmd_t cmd;
  pwr_fetch_t fetch;
  logic [WORD_W-1:0] prog_word = '0;
  logic [1:0] prog_par;
  int miscompares = 0;
  int comparisons = 0;
  int rst_cyc = 0;
  int wake_cnt = 0;
  logic [31:0] q;
  logic e;

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    if (core_reset === 1'b1) rst_cyc <= rst_cyc + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
  end

  pwr_top #(.POWERUP_TIMER_CYCLES(PW), .OST_CYCLES(OS), .WDT_TICKS(20)) pwr_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_pin(por_pin), .bor_pin(bor), .wdt_osc_pin(osc), .cfg_fuse_pin(fuse),
    .fetch(fetch), .cmd(cmd), .prog_word(prog_word), .prog_par(prog_par),
    .core_reset(core_reset), .wake(wake), .sleeping(sleeping));

  pwr_core_model pwr_core_model_inst (
    .pclk(pclk), .presetn(presetn), .core_reset(core_reset), .sleeping(sleeping),
    .corrupt(corrupt), .cmd_req(cmd_req), .fetch(fetch), .cmd(cmd));

  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      clk(3);
      osc <= 1'b1;
      clk(3);
      osc <= 1'b0;
    end
  endtask

  task automatic pulse(input pwr_cmd_t c);
    @(posedge pclk);
    cmd_req <= c;
    @(posedge pclk);
    cmd_req <= '0;
  endtask

  task automatic bad_fetch();
    @(posedge pclk);
    corrupt <= 1'b1;
    @(posedge pclk);
    corrupt <= 1'b0;
    clk(4);
  endtask

  task automatic await_run(input int lo);
    int n;
    n = 0;
    while (core_reset !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chkb(n >= lo && n <= lo + 8, 1'b1, "start-up wait");
    if (core_reset !== 1'b0) begin
      final_report();
    end
  endtask

  task automatic powerup(input logic [7:0] f, input int lo);
    @(posedge pclk);
    presetn <= 1'b0;
    por_pin <= 1'b1;
    fuse <= f;
    clk(8);
    chkb(core_reset, 1'b1, "held in reset");
    presetn <= 1'b1;
    clk(4);
    por_pin <= 1'b0;
    await_run(lo);
  endtask

  initial begin
    int r;
    int w;
    for (int i = 0; i < 4; i++) begin
      powerup(PU_F[i], PU_LO[i]);
      apb(1'b0, A_POWER_CONTROL_STATUS_REG, 32'h0);
      chk(q, {24'h0, PU_F[i][7], 7'h04}, "power_control_status_reg");
      apb(1'b1, A_CFG, 32'h0);
      apb(1'b0, A_CFG, 32'h0);
      chk(q, {24'h0, PU_F[i]}, "fuse word");
      apb(1'b0, A_OPT, 32'h0);
      chk(q, 32'h000000ff, "option");
      apb(1'b0, A_STAT, 32'h0);
      chk(q & 32'h18, 32'h18, "status");
      if (PU_F[i] == 8'h7b) begin
        r = rst_cyc;
        bad_fetch();
        ticks(25);
        chk(rst_cyc - r, 0, "checks disabled");
      end
    end
    foreach (PAR_ROWS[i]) begin
      @(posedge pclk);
      prog_word <= PAR_ROWS[i][15:2];
      @(posedge pclk);
      #1 chk({30'h0, prog_par}, {30'h0, PAR_ROWS[i][1:0]}, "pair");
    end
    r = rst_cyc;
    clk(20);
    chk(rst_cyc - r, 0, "good fetches");
    bad_fetch();
    chk(rst_cyc - r, 1, "parity reset");
    apb(1'b0, A_POWER_CONTROL_STATUS_REG, 32'h0);
    chk(q & 32'h4, 32'h0, "flag cleared");
    clk(20);
    apb(1'b0, A_POWER_CONTROL_STATUS_REG, 32'h0);
    chk(q & 32'h4, 32'h0, "flag stays");
    apb(1'b1, A_POWER_CONTROL_STATUS_REG, 32'h4);
    apb(1'b0, A_POWER_CONTROL_STATUS_REG, 32'h0);
    chk(q & 32'h4, 32'h4, "flag set");
    apb(1'b0, 32'h00000040, 32'h0);
    chkb(e, 1'b1, "unmapped");
    chk(q, 32'h0, "unmapped data");
    apb(1'b0, A_POWER_CONTROL_STATUS_REG | 32'h1, 32'h0);
    chkb(e, 1'b1, "misaligned");
    chk(q, 32'h0, "misaligned data");
    apb(1'b1, A_OPT, 32'h0);
    pulse(CLR);
    r = rst_cyc;
    ticks(19);
    chk(rst_cyc - r, 0, "early time-out");
    ticks(1);
    clk(6);
    chk(rst_cyc - r, 1, "time-out reset");
    apb(1'b0, A_STAT, 32'h0);
    chk(q & 32'h10, 32'h0, "time-out flag");
    apb(1'b1, A_OPT, 32'h09);
    ticks(1);
    pulse(CLR);
    apb(1'b0, A_OPT, 32'h0);
    chk(q, 32'h09, "assignment kept");
    r = rst_cyc;
    ticks(39);
    chk(rst_cyc - r, 0, "divided count");
    ticks(1);
    clk(6);
    chk(rst_cyc - r, 1, "divided time-out");
    apb(1'b1, A_OPT, 32'h0);
    pulse(CLR);
    r = rst_cyc;
    w = wake_cnt;
    ticks(15);
    pulse(CLR);
    ticks(15);
    pulse(SLP);
    clk(2);
    chkb(sleeping, 1'b1, "asleep");
    ticks(15);
    chk(rst_cyc - r + wake_cnt - w, 0, "counter cleared");
    ticks(5);
    clk(40);
    chk(wake_cnt - w, 1, "wake");
    chkb(sleeping, 1'b0, "awake");
    apb(1'b1, A_POWER_CONTROL_STATUS_REG, 32'h7);
    @(posedge pclk);
    bor <= 1'b1;
    clk(4);
    bor <= 1'b0;
    await_run(PW + OS);
    apb(1'b0, A_POWER_CONTROL_STATUS_REG, 32'h0);
    chk(q, 32'h86, "brown-out flag");
    powerup(8'hf7, PW);
    apb(1'b1, A_OPT, 32'h0);
    r = rst_cyc;
    w = wake_cnt;
    pulse(SLP);
    ticks(20);
    clk(6);
    chk(wake_cnt - w, 1, "rc wake");
    chk(rst_cyc - r, 0, "rc wake no reset");
    chkb(sleeping, 1'b0, "rc awake");
    final_report();
  end
endmodule
